// ===== rtl/epi_pkg.sv
package epi_pkg;

  // ----------------------------------------------------------------
  // sizes and reset values
  // ----------------------------------------------------------------
  localparam int unsigned    REQ_COUNT      = 8;
  localparam int unsigned    LEVEL_W        = 3;
  localparam int unsigned    THRESH_W       = 4;
  localparam int unsigned    BYPASS_POS     = 3;
  localparam logic [3:0]     THRESH_RST     = 4'h0;
  localparam logic [7:0]     REQ_LATCH_RST  = 8'h00;
  localparam int unsigned    SYNC_STAGES    = 2;

  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] lvl;
    logic       any;
  } epi_enc_s;

  typedef struct packed {
    logic [2:0] vec_o;
    logic [2:0] vec_oe_n;
  } epi_vec_s;

  // encode highest active level, bit 7 wins
  function automatic epi_enc_s epi_encode(input logic [7:0] req);
    epi_enc_s r;
    r.lvl = 3'h0;
    r.any = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (req[i]) begin
        r.lvl = i[2:0];
        r.any = 1'b1;
      end
    end
    return r;
  endfunction : epi_encode

endpackage : epi_pkg

// ===== rtl/epi_unit.sv
`timescale 1ns/10ps
`default_nettype none

module epi_unit
  import epi_pkg::*;
(
  input  wire logic                        sys_clk,
  input  wire logic                        sys_rst,
  input  wire logic [epi_pkg::REQ_COUNT-1:0] req_n,
  input  wire logic                        status_load_strobe_n,
  input  wire logic [epi_pkg::THRESH_W-1:0]  thresh_din,
  input  wire logic                        interrupt_gate_input,
  input  wire logic                        vector_output_gate_n,
  input  wire logic                        cascade_enable_in,
  input  wire logic                        int_n_i,
  output logic                             int_n_o,
  output logic                             int_n_oe_n,
  output logic                             cascade_enable_out,
  output logic [epi_pkg::LEVEL_W-1:0]        vec_o,
  output logic [epi_pkg::LEVEL_W-1:0]        vec_oe_n
);

  // ----------------------------------------------------------------
  // input synchronisers: all pins except sys_clk and sys_rst are asynchronous to sys_clk
  // ----------------------------------------------------------------
  localparam int unsigned SYN_W = REQ_COUNT + 1 + THRESH_W + 4;

  logic [SYN_W-1:0] syn1_q;
  logic [SYN_W-1:0] syn2_q;
  wire  [SYN_W-1:0] syn_raw;

  // pins go straight into the first flop; inversion waits for the second stage
  assign syn_raw = {req_n, status_load_strobe_n, thresh_din, interrupt_gate_input,
                    vector_output_gate_n, cascade_enable_in, int_n_i};

  always_ff @(posedge sys_clk) begin
    syn1_q <= syn_raw;
    syn2_q <= syn1_q;
  end

  wire [7:0] req_s;
  wire [7:0] req_n_s;
  wire       load_n_s;
  wire [3:0] din_s;
  wire       gate_s;
  wire       vgate_n_s;
  wire       casc_in_s;
  wire       int_bus_n_s;

  assign {req_n_s, load_n_s, din_s, gate_s, vgate_n_s, casc_in_s, int_bus_n_s} = syn2_q;
  assign req_s = ~req_n_s;

  // ----------------------------------------------------------------
  // threshold latch and request lock flop
  // ----------------------------------------------------------------
  logic [3:0] thresh_q;
  logic       lock_q;
  logic [7:0] req_latch_q;
  logic       int_q;

  wire        load_s;
  wire        lock_d;

  assign load_s = ~load_n_s;
  // lock set by our pulse or any unit's pulse on the shared wire; the load wins
  // since software rewrites the threshold precisely to reopen the latch
  assign lock_d = load_s ? 1'b0 :
                  (lock_q | int_q | ~int_bus_n_s);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      thresh_q <= THRESH_RST;
      lock_q   <= 1'b0;
    end else begin
      if (load_s) begin
        thresh_q <= din_s;
      end
      lock_q <= lock_d;
    end
  end

  // ----------------------------------------------------------------
  // request latch: transparent while unlocked, frozen when locked
  // ----------------------------------------------------------------
  // a request dropped while open is forgotten; the latch keeps no history
  wire [7:0] req_latch_d;

  assign req_latch_d = lock_d ? req_latch_q : req_s;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      req_latch_q <= REQ_LATCH_RST;
    end else begin
      req_latch_q <= req_latch_d;
    end
  end

  // ----------------------------------------------------------------
  // encoder and comparator
  // ----------------------------------------------------------------
  epi_enc_s   enc;
  wire  [2:0] thr_lvl;
  wire        bypass;
  wire        cmp_gt;
  wire        qualify;
  wire        int_d;

  assign enc     = epi_encode(req_latch_q);
  assign thr_lvl = ~thresh_q[LEVEL_W-1:0];
  assign bypass  = ~thresh_q[BYPASS_POS];
  // strict compare: equal levels, including both zero, qualify only through bypass (thresh_q bit 3 low)
  assign cmp_gt  = enc.lvl > thr_lvl;
  assign qualify = enc.any & (bypass | cmp_gt);
  // one-clock pulse: once issued the lock blocks a second set
  assign int_d   = qualify & gate_s & casc_in_s & ~lock_q & ~int_q;

  // ----------------------------------------------------------------
  // outputs, all registered
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      int_q              <= 1'b0;
      int_n_o            <= 1'b0;
      int_n_oe_n         <= 1'b1;
      cascade_enable_out <= 1'b0;
      vec_o              <= 3'h0;
      vec_oe_n           <= 3'h7;
    end else begin
      int_q              <= int_d;
      int_n_o            <= 1'b0;
      int_n_oe_n         <= ~int_d;
      cascade_enable_out <= casc_in_s & ~qualify;
      vec_o              <= 3'h0;
      // open collector: pull low where the complemented level bit is zero
      vec_oe_n           <= vgate_n_s ? 3'h7 : ~enc.lvl;
    end
  end

endmodule : epi_unit

`default_nettype wire

// ===== tb/epi_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
module epi_cpu_model (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       int_n_i,
  input  wire logic [2:0] vec_wire,
  output var  logic [7:0] n_int,
  output var  logic [2:0] vec_got
);
  // the pulse lasts one clock, so it is caught here
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      n_int <= 8'h00;
    end else if (int_n_i == 1'b0) begin
      n_int   <= n_int + 8'h01;
      vec_got <= vec_wire;
    end
  end
endmodule : epi_cpu_model
`default_nettype wire

// ===== tb/epi_unit_properties.sv
`timescale 1ns/10ps
`default_nettype none
module epi_unit_properties (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic [7:0] req_n,
  input wire logic       status_load_strobe_n,
  input wire logic       interrupt_gate_input,
  input wire logic       vector_output_gate_n,
  input wire logic       cascade_enable_in,
  input wire logic       int_n_o,
  input wire logic       int_n_oe_n,
  input wire logic       cascade_enable_out,
  input wire logic [2:0] vec_o,
  input wire logic [2:0] vec_oe_n
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  chk_one_clock_pulse: assert property ($fell(int_n_oe_n) |=> int_n_oe_n)
    else $error("pulse too long");
  chk_gate_blocks_int: assert property ((!interrupt_gate_input)[*4] |-> int_n_oe_n)
    else $error("pulse while gated");
  chk_cascade_in_low: assert property ((!cascade_enable_in)[*4] |-> int_n_oe_n && !cascade_enable_out)
    else $error("cascade in ignored");
  chk_vector_gate_off: assert property (vector_output_gate_n[*4] |-> vec_oe_n == 3'h7)
    else $error("vector driven while off");
  chk_open_collector: assert property (int_n_o == 1'b0 && vec_o == 3'h0)
    else $error("open collector data high");
  chk_lock_holds_off: assert property ((status_load_strobe_n[*4] ##0 !int_n_oe_n) |=> int_n_oe_n[*4])
    else $error("pulse while locked");
  chk_pending_cascade: assert property (!int_n_oe_n |-> !cascade_enable_out)
    else $error("cascade out high while pending");
  chk_quiet_no_int: assert property ((&req_n && status_load_strobe_n)[*6] |-> int_n_oe_n)
    else $error("pulse without request");
endmodule : epi_unit_properties
bind epi_unit epi_unit_properties i_epi_unit_properties (.*);
`default_nettype wire

// ===== tb/epi_unit_tb.sv
`timescale 1ns/10ps
`default_nettype none
module epi_unit_tb;
  import epi_pkg::*;
  typedef struct packed {logic [7:0] rq; logic [3:0] th; logic hit; logic [2:0] vw;} epi_row_s;
  logic sys_clk = 1'b0, sys_rst = 1'b1, status_load_strobe_n = 1'b1;
  logic interrupt_gate_input = 1'b1, vector_output_gate_n = 1'b0;
  logic cascade_enable_in = 1'b1; // first unit sees cascade in high
  logic [7:0] req_n = 8'hff;
  logic [3:0] thresh_din = 4'h0;
  wire logic int_n_i, int_n_o, int_n_oe_n, cascade_enable_out;
  wire logic [2:0] vec_o, vec_oe_n, vec_wire, vec_got;
  wire logic [7:0] n_int;
  logic [7:0] base;
  int mismatches = 0, n_compared = 0, k;
  // pull-ups on the shared wires
  assign int_n_i = int_n_oe_n ? 1'b1 : int_n_o;
  assign vec_wire = vec_o | vec_oe_n;
  epi_row_s rows [6] = '{'{8'h7e, 4'h0, 1'b1, 3'h0}, '{8'h7f, 4'h8, 1'b0, 3'h0},
    '{8'h7f, 4'h9, 1'b1, 3'h0}, '{8'hf7, 4'hc, 1'b0, 3'h0},
    '{8'hfe, 4'hf, 1'b0, 3'h0}, '{8'hfe, 4'h7, 1'b1, 3'h7}};
  epi_unit i_epi_unit (.*);
  epi_cpu_model i_epi_cpu_model (.*);
  always #2 sys_clk = ~sys_clk;
  task automatic check(input string nm, input logic [2:0] e, input logic [2:0] g);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask : check
  // strobe held three clocks so a stale latch cannot relock
  task automatic load(input logic [3:0] v);
    @(posedge sys_clk) status_load_strobe_n <= 1'b0;
    thresh_din <= v;
    repeat (3) @(posedge sys_clk);
    status_load_strobe_n <= 1'b1;
    repeat (6) @(posedge sys_clk);
  endtask : load
  task automatic apply(input logic [7:0] r, input logic h, input logic [2:0] v);
    base = n_int;
    @(posedge sys_clk) req_n <= r;
    for (k = 0; k < 10 && n_int == base; k++) @(posedge sys_clk);
    check("interrupt", {2'b0, h}, {2'b0, n_int != base});
    if (h) check("vector", v, vec_got);
  endtask : apply
  task automatic conclude();
    if (mismatches == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : conclude
  initial begin
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    foreach (rows[i]) begin
      load(rows[i].th);
      apply(rows[i].rq, rows[i].hit, rows[i].vw);
      req_n <= 8'hff;
    end
    load(4'h0);
    interrupt_gate_input <= 1'b0;
    apply(8'hfd, 1'b0, 3'h0);
    check("cascade_out", 3'h0, {2'b0, cascade_enable_out});
    interrupt_gate_input <= 1'b1;
    apply(8'hfd, 1'b1, 3'h6);
    apply(8'hbf, 1'b0, 3'h0);
    req_n <= 8'hff;
    load(4'h0);
    cascade_enable_in <= 1'b0;
    apply(8'hfb, 1'b0, 3'h0);
    check("cascade_out", 3'h0, {2'b0, cascade_enable_out});
    cascade_enable_in <= 1'b1;
    apply(8'hfb, 1'b1, 3'h5);
    req_n <= 8'hff;
    vector_output_gate_n <= 1'b1;
    load(4'h0);
    apply(8'hf7, 1'b1, 3'h7);
    req_n <= 8'hff;
    load(4'h0);
    check("cascade_out", 3'h1, {2'b0, cascade_enable_out});
    conclude();
  end
endmodule : epi_unit_tb
`default_nettype wire
